// [core/lmd_pkg.sv]
// constants and encodings shared by the load and multiply operand decoder
package lmd_pkg;
  // operation classes
  localparam int          OP_W            = 2;
  localparam logic [1:0]  OP_LOAD_MOVE    = 2'h0;
  localparam logic [1:0]  OP_MULT_ONLY    = 2'h1;
  localparam logic [1:0]  OP_MULT_ADD     = 2'h2;
  localparam logic [1:0]  OP_MULT_SUB     = 2'h3;
  // operand kinds
  localparam int          KIND_W          = 4;
  localparam logic [3:0]  KIND_HWREGS     = 4'h0;
  localparam logic [3:0]  KIND_DREGS      = 4'h1;
  localparam logic [3:0]  KIND_PREGS      = 4'h2;
  localparam logic [3:0]  KIND_REGIND     = 4'h3;
  localparam logic [3:0]  KIND_MEMIND     = 4'h4;
  localparam logic [3:0]  KIND_ACCIND     = 4'h5;
  localparam logic [3:0]  KIND_DIRECT     = 4'h6;
  localparam logic [3:0]  KIND_SIMM       = 4'h7;
  localparam logic [3:0]  KIND_LIMM       = 4'h8;
  // hardware register codes; codes with the top bit set are external_register_n
  localparam int          HW_W            = 4;
  localparam logic [3:0]  HW_X            = 4'h0;
  localparam logic [3:0]  HW_Y            = 4'h1;
  localparam logic [3:0]  HW_A            = 4'h2;
  localparam logic [3:0]  HW_P            = 4'h3;
  localparam logic [3:0]  HW_PC           = 4'h4;
  localparam logic [3:0]  HW_STATUS_WORD  = 4'h5;
  localparam logic [3:0]  HW_STACK        = 4'h6;
  localparam logic [3:0]  HW_BUS          = 4'h7;
  localparam int          HW_EXT_BIT      = 3;
  // data ram banks and bank-swap defaults
  localparam logic        BANK_SRC1       = 1'b1;
  localparam logic        BANK_SRC2       = 1'b0;
  localparam logic        SWAP_DEF_HW_IND = 1'b0;
  localparam logic        SWAP_DEF_IND_IND = 1'b1;
  // words and cycles
  localparam int          CYC_W           = 2;
  localparam logic [1:0]  CNT_ONE         = 2'h1;
  localparam logic [1:0]  CNT_TWO         = 2'h2;
  localparam logic [1:0]  CNT_THREE       = 2'h3;
  // error codes
  localparam int          ERR_W           = 3;
  localparam logic [2:0]  ERR_NONE        = 3'h0;
  localparam logic [2:0]  ERR_COMBO       = 3'h1;
  localparam logic [2:0]  ERR_DEST_P      = 3'h2;
  localparam logic [2:0]  ERR_SAME_HW     = 3'h3;
  localparam logic [2:0]  ERR_SRC1_BANK   = 3'h4;
  localparam logic [2:0]  ERR_SRC2_BANK   = 3'h5;
  localparam logic [2:0]  ERR_SRC1_X      = 3'h6;
endpackage : lmd_pkg

// [core/lmd_hold_if.sv]
// carrier between the decoder and its issue-hold counter
`timescale 1ns/100ps
interface lmd_hold_if;
  logic                           start;
  logic [lmd_pkg::CYC_W-1:0]      cycles;
  logic                           busy;
  modport dec  (output start, output cycles, input busy);
  modport hold (input start, input cycles, output busy);
endinterface : lmd_hold_if

// [core/lmd_hold.sv]
// issue-hold counter that stalls fetch for multi-cycle forms
`timescale 1ns/100ps
module lmd_hold (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  lmd_hold_if.hold  hif
);
  typedef enum logic {LMD_IDLE, LMD_HOLD} lmd_hold_state_t;

  lmd_hold_state_t              state;
  logic [lmd_pkg::CYC_W-1:0]    cnt;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= LMD_IDLE;
    end else begin
      unique case (state)
        LMD_IDLE: begin
          if (hif.start && hif.cycles > lmd_pkg::CNT_ONE) begin
            state <= LMD_HOLD;
          end
        end
        LMD_HOLD: begin
          if (cnt == lmd_pkg::CNT_ONE) begin
            state <= LMD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (state == LMD_IDLE && hif.start) begin
      cnt <= hif.cycles - lmd_pkg::CNT_ONE;
    end else if (state == LMD_HOLD) begin
      cnt <= cnt - lmd_pkg::CNT_ONE;
    end
  end

  assign hif.busy = (state == LMD_HOLD);
endmodule : lmd_hold

// [core/lmd_decode.sv]
// operand legality and bank selection for load_move and the multiply class
// Overview of operation
// RULE_01 - load into a hardware register never targets the product register P.
// RULE_02 - register-to-register load rejects any external to external, X to X, status to status.
// RULE_03 - indirect first multiply source must use data ram bank 1.
// RULE_04 - indirect second multiply source must use data ram bank 0.
// RULE_05 - multiply first source as hardware register may not be X.
// RULE_06 - hardware plus indirect multiply: bank swap defaults off.
// RULE_07 - two indirect multiply operands: bank swap defaults on.
// RULE_08 - indirect program or accumulator loads 3 cycles; long immediate 2; multiply 1. The decoder times long immediate to register indirect at 1.
`timescale 1ns/100ps
module lmd_decode (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          instr_valid,
  input  wire logic [lmd_pkg::OP_W-1:0]      instr_op,
  input  wire logic [lmd_pkg::KIND_W-1:0]    dest_kind,
  input  wire logic [lmd_pkg::KIND_W-1:0]    src_kind,
  input  wire logic [lmd_pkg::HW_W-1:0]      dest_hw,
  input  wire logic [lmd_pkg::HW_W-1:0]      src_hw,
  input  wire logic                          dest_bank,
  input  wire logic                          src_bank,
  input  wire logic                          swap_given,
  input  wire logic                          swap_value,
  output      logic                          instr_ready,
  output      logic                          dec_valid,
  output      logic                          dec_illegal,
  output      logic [lmd_pkg::ERR_W-1:0]     dec_err,
  output      logic [lmd_pkg::CYC_W-1:0]     dec_words,
  output      logic [lmd_pkg::CYC_W-1:0]     dec_cycles,
  output      logic                          hw_we,
  output      logic [lmd_pkg::HW_W-1:0]      hw_sel,
  output      logic                          mult_start,
  output      logic                          mult_add,
  output      logic                          mult_sub,
  output      logic                          ptr1_bank,
  output      logic                          ptr2_bank,
  output      logic                          bank_swap
);
  // for the multiply class dest_* fields carry the first source, src_* the second
  lmd_hold_if hif ();

  logic                        is_load;
  logic                        take;
  logic                        combo_ok;
  logic [lmd_pkg::ERR_W-1:0]   next_err;
  logic [lmd_pkg::CYC_W-1:0]   next_words;
  logic [lmd_pkg::CYC_W-1:0]   next_cycles;
  logic                        next_swap;
  logic                        dest_ext;
  logic                        src_ext;

  assign is_load  = (instr_op == lmd_pkg::OP_LOAD_MOVE);
  assign take     = instr_valid && instr_ready;
  assign dest_ext = dest_hw[lmd_pkg::HW_EXT_BIT];
  assign src_ext  = src_hw[lmd_pkg::HW_EXT_BIT];

  // operand pairings that exist at all
  always_comb begin
    combo_ok = 1'b0;
    if (is_load) begin
      unique case (dest_kind)
        lmd_pkg::KIND_HWREGS: begin
          combo_ok = (src_kind == lmd_pkg::KIND_HWREGS) ||
                     (src_kind == lmd_pkg::KIND_DREGS)  ||
                     (src_kind == lmd_pkg::KIND_PREGS)  ||
                     (src_kind == lmd_pkg::KIND_REGIND) ||
                     (src_kind == lmd_pkg::KIND_MEMIND) ||
                     (src_kind == lmd_pkg::KIND_ACCIND) ||
                     (src_kind == lmd_pkg::KIND_LIMM)   ||
                     (src_kind == lmd_pkg::KIND_DIRECT && dest_hw == lmd_pkg::HW_A);
        end
        lmd_pkg::KIND_DIRECT: begin
          combo_ok = (src_kind == lmd_pkg::KIND_HWREGS) && (src_hw == lmd_pkg::HW_A);
        end
        lmd_pkg::KIND_DREGS: begin
          combo_ok = (src_kind == lmd_pkg::KIND_HWREGS);
        end
        lmd_pkg::KIND_PREGS: begin
          combo_ok = (src_kind == lmd_pkg::KIND_HWREGS) ||
                     (src_kind == lmd_pkg::KIND_SIMM);
        end
        lmd_pkg::KIND_REGIND: begin
          combo_ok = (src_kind == lmd_pkg::KIND_HWREGS) ||
                     (src_kind == lmd_pkg::KIND_LIMM);
        end
        default: begin
          combo_ok = 1'b0;
        end
      endcase
    end else begin
      combo_ok = (dest_kind == lmd_pkg::KIND_HWREGS || dest_kind == lmd_pkg::KIND_REGIND) &&
                 (src_kind == lmd_pkg::KIND_REGIND);
    end
  end

  // first failing check wins; combination errors mask the finer checks
  always_comb begin
    next_err = lmd_pkg::ERR_NONE;
    if (!combo_ok) begin
      next_err = lmd_pkg::ERR_COMBO;
    end else if (is_load) begin
      // RULE_01 product register guard
      if (dest_kind == lmd_pkg::KIND_HWREGS && dest_hw == lmd_pkg::HW_P) begin
        next_err = lmd_pkg::ERR_DEST_P;
      // RULE_02 external pairs and same register pairs
      end else if (dest_kind == lmd_pkg::KIND_HWREGS && src_kind == lmd_pkg::KIND_HWREGS &&
                   ((dest_ext && src_ext) ||
                    (dest_hw == lmd_pkg::HW_X && src_hw == lmd_pkg::HW_X) ||
                    (dest_hw == lmd_pkg::HW_STATUS_WORD &&
                     src_hw == lmd_pkg::HW_STATUS_WORD))) begin
        next_err = lmd_pkg::ERR_SAME_HW;
      end
    end else begin
      // RULE_03 first pointer bank
      if (dest_kind == lmd_pkg::KIND_REGIND && dest_bank != lmd_pkg::BANK_SRC1) begin
        next_err = lmd_pkg::ERR_SRC1_BANK;
      // RULE_04 second pointer bank
      end else if (src_bank != lmd_pkg::BANK_SRC2) begin
        next_err = lmd_pkg::ERR_SRC2_BANK;
      // RULE_05 no X as first source
      end else if (dest_kind == lmd_pkg::KIND_HWREGS && dest_hw == lmd_pkg::HW_X) begin
        next_err = lmd_pkg::ERR_SRC1_X;
      end
    end
  end

  // bank swap: explicit option first, otherwise the default of the operand form
  always_comb begin
    next_swap = 1'b0;
    if (!is_load) begin
      if (swap_given) begin
        next_swap = swap_value;
      // RULE_06 hardware plus indirect default
      end else if (dest_kind == lmd_pkg::KIND_HWREGS) begin
        next_swap = lmd_pkg::SWAP_DEF_HW_IND;
      // RULE_07 indirect pair default
      end else begin
        next_swap = lmd_pkg::SWAP_DEF_IND_IND;
      end
    end
  end

  // an illegal form costs one word and one cycle so fetch is never wedged
  always_comb begin
    next_words  = lmd_pkg::CNT_ONE;
    next_cycles = lmd_pkg::CNT_ONE;
    if (is_load && next_err == lmd_pkg::ERR_NONE) begin
      // RULE_08 load timing
      if (src_kind == lmd_pkg::KIND_MEMIND || src_kind == lmd_pkg::KIND_ACCIND) begin
        next_cycles = lmd_pkg::CNT_THREE;
      end else if (dest_kind == lmd_pkg::KIND_HWREGS && src_kind == lmd_pkg::KIND_LIMM) begin
        next_words  = lmd_pkg::CNT_TWO;
        next_cycles = lmd_pkg::CNT_TWO;
      end
    end
  end

  // RULE_08 stall fetch for multi-cycle forms
  assign hif.start  = take;
  assign hif.cycles = next_cycles;
  assign instr_ready = !hif.busy;

  lmd_hold u_hold (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .hif     (hif)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= take;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dec_illegal <= 1'b0;
      dec_err     <= lmd_pkg::ERR_NONE;
      dec_words   <= lmd_pkg::CNT_ONE;
      dec_cycles  <= lmd_pkg::CNT_ONE;
    end else if (take) begin
      dec_illegal <= (next_err != lmd_pkg::ERR_NONE);
      dec_err     <= next_err;
      dec_words   <= next_words;
      dec_cycles  <= next_cycles;
    end
  end

  // strobes last one cycle; an illegal form writes nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hw_we <= 1'b0;
      hw_sel <= '0;
    end else begin
      // RULE_01 write enable withheld
      hw_we <= take && is_load && dest_kind == lmd_pkg::KIND_HWREGS &&
               next_err == lmd_pkg::ERR_NONE;
      if (take) begin
        hw_sel <= dest_hw;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mult_start <= 1'b0;
      mult_add   <= 1'b0;
      mult_sub   <= 1'b0;
    end else begin
      mult_start <= take && !is_load && next_err == lmd_pkg::ERR_NONE;
      mult_add   <= take && instr_op == lmd_pkg::OP_MULT_ADD && next_err == lmd_pkg::ERR_NONE;
      mult_sub   <= take && instr_op == lmd_pkg::OP_MULT_SUB && next_err == lmd_pkg::ERR_NONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ptr1_bank <= lmd_pkg::BANK_SRC1;
      ptr2_bank <= lmd_pkg::BANK_SRC2;
      bank_swap <= 1'b0;
    end else if (take) begin
      // RULE_03 bank 1 for first pointer
      ptr1_bank <= lmd_pkg::BANK_SRC1;
      // RULE_04 bank 0 for second pointer
      ptr2_bank <= lmd_pkg::BANK_SRC2;
      bank_swap <= next_swap;
    end
  end
endmodule : lmd_decode

// [testbench/lmd_decode_monitor.sv]
// assertion checker on the decoder top ports
`timescale 1ns/100ps
module lmd_decode_chk (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       instr_valid,
  input wire logic [1:0] instr_op,
  input wire logic [3:0] dest_kind,
  input wire logic [3:0] src_kind,
  input wire logic [3:0] dest_hw,
  input wire logic [3:0] src_hw,
  input wire logic       dest_bank,
  input wire logic       src_bank,
  input wire logic       swap_given,
  input wire logic       instr_ready,
  input wire logic       dec_valid,
  input wire logic       dec_illegal,
  input wire logic [1:0] dec_words,
  input wire logic [1:0] dec_cycles,
  input wire logic       hw_we,
  input wire logic [3:0] hw_sel,
  input wire logic       mult_start,
  input wire logic       ptr1_bank,
  input wire logic       ptr2_bank,
  input wire logic       bank_swap
);
  logic take;
  logic mul;
  logic hh;
  assign take = instr_valid && instr_ready;
  assign mul  = take && (instr_op != lmd_pkg::OP_LOAD_MOVE);
  assign hh   = take && !mul && dest_kind == lmd_pkg::KIND_HWREGS && src_kind == dest_kind;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_dest_not_p: assert property (hw_we |-> hw_sel != lmd_pkg::HW_P)
    else $error("load wrote the product register");
  a_same_pair: assert property (hh && ((dest_hw[3] && src_hw[3]) || (dest_hw == src_hw &&
    (dest_hw == lmd_pkg::HW_X || dest_hw == lmd_pkg::HW_STATUS_WORD))) |=> dec_illegal && !hw_we)
    else $error("same register pair not rejected");
  a_src1_bank: assert property (mul && dest_kind == lmd_pkg::KIND_REGIND && !dest_bank
    |=> dec_illegal && !mult_start && ptr1_bank) else $error("first source bank not 1");
  a_src2_bank: assert property (mul && src_kind == lmd_pkg::KIND_REGIND && src_bank
    |=> dec_illegal && !mult_start && !ptr2_bank) else $error("second source bank not 0");
  a_src1_not_x: assert property (mul && dest_kind == lmd_pkg::KIND_HWREGS &&
    dest_hw == lmd_pkg::HW_X |=> dec_illegal && !mult_start) else $error("X taken as source");
  a_swap_off: assert property (mul && dest_kind == lmd_pkg::KIND_HWREGS && !swap_given
    |=> !bank_swap) else $error("swap not off by default");
  a_swap_on: assert property (mul && dest_kind == lmd_pkg::KIND_REGIND &&
    src_kind == dest_kind && !swap_given |=> bank_swap) else $error("swap not on by default");
  a_three_hold: assert property (dec_valid && dec_cycles == 2'h3 |->
    !instr_ready [*2] ##1 instr_ready) else $error("three cycle hold wrong");
  a_two_words: assert property (dec_valid && dec_words == 2'h2 |-> dec_cycles == 2'h2
    ##0 !instr_ready ##1 instr_ready) else $error("long immediate timing wrong");
  a_mult_single: assert property (mult_start |-> dec_valid && dec_cycles == 2'h1 &&
    dec_words == 2'h1 && instr_ready) else $error("multiply not single cycle");
  c_swap_on: cover property (mul ##1 bank_swap);
  c_three: cover property (dec_valid && dec_cycles == 2'h3);
  c_illegal: cover property (dec_valid && dec_illegal);
endmodule : lmd_decode_chk
bind lmd_decode lmd_decode_chk chk_u (.ref_clk, .sys_rst, .instr_valid, .instr_op, .dest_kind,
  .src_kind, .dest_hw, .src_hw, .dest_bank, .src_bank, .swap_given, .instr_ready, .dec_valid,
  .dec_illegal, .dec_words, .dec_cycles, .hw_we, .hw_sel, .mult_start, .ptr1_bank, .ptr2_bank,
  .bank_swap);

// [testbench/lmd_decode_tb_top.sv]
// self-checking bench for the load and multiply operand decoder
`timescale 1ns/100ps
module lmd_decode_tb_top;
  localparam logic [3:0] HR = lmd_pkg::KIND_HWREGS, RI = lmd_pkg::KIND_REGIND,
    MI = lmd_pkg::KIND_MEMIND, AI = lmd_pkg::KIND_ACCIND, LI = lmd_pkg::KIND_LIMM,
    DR = lmd_pkg::KIND_DREGS, DI = lmd_pkg::KIND_DIRECT, RX = lmd_pkg::HW_X,
    RA = lmd_pkg::HW_A, RP = lmd_pkg::HW_P, RS = lmd_pkg::HW_STATUS_WORD;
  localparam logic [1:0] LDM = lmd_pkg::OP_LOAD_MOVE, MUL = lmd_pkg::OP_MULT_ONLY,
    MAD = lmd_pkg::OP_MULT_ADD, MSU = lmd_pkg::OP_MULT_SUB;
  localparam logic [2:0] E0 = lmd_pkg::ERR_NONE, EC = lmd_pkg::ERR_COMBO,
    EP = lmd_pkg::ERR_DEST_P, ES = lmd_pkg::ERR_SAME_HW, E1 = lmd_pkg::ERR_SRC1_BANK,
    E2 = lmd_pkg::ERR_SRC2_BANK, EX = lmd_pkg::ERR_SRC1_X;
  logic        ref_clk, sys_rst, instr_valid, dest_bank, src_bank, swap_given, swap_value;
  logic        instr_ready, dec_valid, dec_illegal, hw_we, mult_start, mult_add, mult_sub;
  logic        ptr1_bank, ptr2_bank, bank_swap;
  logic [1:0]  instr_op, dec_words, dec_cycles;
  logic [2:0]  dec_err;
  logic [3:0]  dest_kind, src_kind, dest_hw, src_hw, hw_sel;
  logic [18:0] expq[$];
  logic [18:0] e;
  int          mismatches, num_checks, i;
  lmd_decode dut_u (.ref_clk, .sys_rst, .instr_valid, .instr_op, .dest_kind, .src_kind,
    .dest_hw, .src_hw, .dest_bank, .src_bank, .swap_given, .swap_value, .instr_ready,
    .dec_valid, .dec_illegal, .dec_err, .dec_words, .dec_cycles, .hw_we, .hw_sel,
    .mult_start, .mult_add, .mult_sub, .ptr1_bank, .ptr2_bank, .bank_swap);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task check(input string name, input logic [18:0] exp, input logic [18:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // expectation noted before the request goes out
  task send(input logic [1:0] op, input logic [3:0] dk, sk, dh, sh,
            input logic db, sb, sg, sv, input logic [2:0] er);
    logic       ld, ok;
    logic [1:0] w, c;
    int         n;
    ld = op == LDM;
    ok = er == E0;
    w = (ok && ld && dk == HR && sk == LI) ? 2'h2 : 2'h1;
    c = (ok && ld && (sk == MI || sk == AI)) ? 2'h3 : w;
    // hw_sel follows dest_hw on every take; pointer banks are fixed by the rules
    expq.push_back({!ok, er, w, c, ok && ld && dk == HR, ok && !ld, ok && op == MAD,
                    ok && op == MSU, !ld && (sg ? sv : dk == RI), dh,
                    lmd_pkg::BANK_SRC1, lmd_pkg::BANK_SRC2});
    @(negedge ref_clk);
    {instr_valid, instr_op, dest_kind, src_kind, dest_hw, src_hw} = {1'b1, op, dk, sk, dh, sh};
    {dest_bank, src_bank, swap_given, swap_value} = {db, sb, sg, sv};
    n = 0;
    // held while a multi-cycle form blocks issue
    while (instr_ready !== 1'b1) begin
      n++;
      if (n > 8) begin
        mismatches++;
        finish_test();
      end
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
  endtask : send
  always @(negedge ref_clk) begin
    if (!sys_rst && dec_valid === 1'b1) begin
      e = (expq.size() == 0) ? 19'h7ffff : expq.pop_front();
      check("decode", e, {dec_illegal, dec_err, dec_words, dec_cycles, hw_we, mult_start,
        mult_add, mult_sub, bank_swap, hw_sel, ptr1_bank, ptr2_bank});
    end
  end
  initial begin
    {instr_valid, instr_op, dest_kind, src_kind, dest_hw, src_hw} = '0;
    {dest_bank, src_bank, swap_given, swap_value} = '0;
    sys_rst = 1'b1;
    void'($urandom(8));
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    check("reset", 19'h02802, {dec_illegal, dec_err, dec_words, dec_cycles, hw_we,
      mult_start, mult_add, mult_sub, bank_swap, hw_sel, ptr1_bank, ptr2_bank});
    check("idle", 19'h00006, {16'h0, instr_ready, ptr1_bank, ptr2_bank});
    send(LDM, HR, DR, RP, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, EP);
    send(LDM, HR, HR, 4'hc, 4'h9, 1'h0, 1'h0, 1'h0, 1'h0, ES);
    send(LDM, HR, HR, RX, RX, 1'h0, 1'h0, 1'h0, 1'h0, ES);
    send(LDM, HR, HR, RS, RS, 1'h0, 1'h0, 1'h0, 1'h0, ES);
    send(LDM, HR, HR, RX, 4'he, 1'h0, 1'h0, 1'h0, 1'h0, E0);
    send(LDM, HR, MI, RA, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, E0);
    send(LDM, HR, AI, RX, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, E0);
    send(LDM, HR, LI, lmd_pkg::HW_PC, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, E0);
    send(LDM, DI, DR, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, EC);
    send(MUL, HR, HR, RA, RA, 1'h0, 1'h0, 1'h0, 1'h0, EC);
    send(MUL, RI, RI, 4'h0, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, E1);
    send(MAD, RI, RI, 4'h0, 4'h0, 1'h1, 1'h1, 1'h0, 1'h0, E2);
    send(MSU, HR, RI, RX, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, EX);
    for (i = 1; i < 4; i++) begin
      send(i[1:0], HR, RI, RA, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, E0);
      send(i[1:0], RI, RI, 4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h0, E0);
    end
    send(MUL, RI, RI, 4'h0, 4'h0, 1'h1, 1'h0, 1'h1, 1'h0, E0);
    send(MAD, HR, RI, RA, 4'h0, 1'h0, 1'h0, 1'h1, 1'h1, E0);
    // random legal traffic, back to back
    for (i = 0; i < 16; i++) begin
      send(LDM, HR, HR, RA, 4'($urandom % 16), 1'h0, 1'h0, 1'h0, 1'h0, E0);
      send(2'(1 + $urandom % 3), HR, RI, 4'(1 + $urandom % 15), 4'h0, 1'h0, 1'h0,
           1'($urandom), 1'($urandom), E0);
    end
    @(negedge ref_clk) instr_valid = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("drained", 19'h0, 19'(expq.size()));
    finish_test();
  end
endmodule : lmd_decode_tb_top
